// file: pwt_pkg.sv
package pwt_pkg;

	localparam int          ADDR_W            = 16;
	localparam int          DATA_W            = 8;
	localparam int          CNT_W             = 6;
	localparam int          PRE_W             = 11;
	localparam int          OSC_W             = 17;

	localparam logic [15:0] SYS_OPTION_ADDR   = 16'h1802;
	localparam logic [15:0] SYS_TEST_ADDR     = 16'h180F;
	localparam logic [15:0] WAKE_PRESCALE_ADDR = 16'h1820;
	localparam logic [15:0] WAKE_INTERVAL_ADDR = 16'h1821;
	localparam logic [15:0] RST_INTERVAL_ADDR = 16'h1822;
	localparam logic [15:0] WAKE_STATUS_ADDR  = 16'h1823;

	localparam int          THERM_EN_BIT      = 3;
	localparam int          THERM_HIGH_BIT    = 2;
	localparam int          OUT_RANGE_BIT     = 0;
	localparam int          WAKE_FLAG_BIT     = 7;
	localparam int          WAKE_ACK_BIT      = 6;
	localparam int          CNT_SEL_BIT       = 7;

	localparam logic [5:0]  PRESCALE_RESET    = 6'h1F;
	localparam logic [5:0]  WAKE_INT_RESET    = 6'h3F;
	localparam logic [5:0]  RST_INT_RESET     = 6'h00;
	localparam logic [5:0]  CNT_DISABLED_LIM  = 6'h3F;

	localparam int          PRESCALE_BASE     = 504;
	localparam int          PRESCALE_STEP     = 16;

	localparam int          CLK_PERIOD_NS     = 10;
	localparam int          OSC_PERIOD_MS     = 1;
	localparam int          OSC_TICK_CYCLES   =
		(OSC_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} pwt_bus_req_t;

	typedef struct packed {
		logic in_reset_range;
		logic outside_rearm;
	} pwt_temp_t;

endpackage : pwt_pkg

// file: pwt_count6.sv
`timescale 1ns/100ps
module pwt_count6 #(
	parameter int W = 6
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         clear,
	input  wire logic         step,
	input  wire logic [W-1:0] limit,
	output logic      [W-1:0] count,
	output logic              fire
);
	logic [W-1:0] count_reg;
	logic [W-1:0] count_inc;

	assign count_inc = count_reg + {{(W-1){1'b0}}, 1'b1};
	// a zero limit never matches, so that stage stays silent
	assign fire      = step && (limit != '0) && (count_inc == limit);
	assign count     = count_reg;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count_reg <= '0;
		end else if (clear) begin
			count_reg <= '0;
		end else if (fire) begin
			count_reg <= '0;
		end else if (step) begin
			count_reg <= count_inc;
		end
	end

endmodule : pwt_count6

// file: pwt_wake_timer.sv
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
// Summary of operation
// - periodic wake interrupt, optional periodic reset
// - oscillator and timer always run
// - never both wake and reset disabled
// - wake interrupt has no mask
// - 64-step prescaler forms wake clock
// - two cascaded 6-bit interval counters
// - wake interval counts wake clock pulses
// - reset interval counts wake events
// - counters count up, fire, return zero
// - coincident reset suppresses wake interrupt
// - out-of-range thermal blocks wake and reset
// - select bit chooses counter readback
// - return to normal range resets processor
// - thermal enable bit 3, reset clears
// - threshold select cleared by reset
// - restart only after leaving re-arm range
// - out-of-range status bit 0, reset sets
// - enable refused while status reads zero
// - prescale period 504+16n, power-on $1F
// - wake flag set, cleared by ack
// - wake interval preset, change restarts
// - zero wake interval disables, maybe refused
module pwt_wake_timer
	import pwt_pkg::*;
#(
	parameter int OSC_CYCLES = pwt_pkg::OSC_TICK_CYCLES
) (
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire pwt_pkg::pwt_bus_req_t bus_req,
	output logic [7:0]               rdata,
	input  wire pwt_pkg::pwt_temp_t  temp_pin,
	input  wire logic                mcu_reset_req,
	output logic                     wake_irq,
	output logic                     mcu_reset_out,
	output logic                     thermal_high_select
);
	import pwt_pkg::*;

	// last prescaler count of one wake clock period
	function automatic logic [PRE_W-1:0] pre_last(input logic [5:0] s);
		pre_last = PRE_W'(PRESCALE_BASE - 1) +
			PRE_W'(PRESCALE_STEP) * {{(PRE_W-6){1'b0}}, s};
	endfunction : pre_last

	function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
		hit = (a == b);
	endfunction : hit

	// clearing one interval while the other is zero would silence both
	function automatic logic zero_refused(input logic [5:0] value,
		input logic [5:0] other);
		zero_refused = (value == 6'h00) && (other == 6'h00);
	endfunction : zero_refused

	logic [OSC_W-1:0] osc_cnt_reg;
	logic             osc_tick;
	logic [PRE_W-1:0] pre_cnt_reg;
	logic             wake_clk;
	logic [5:0]       prescale_reg;
	logic [5:0]       wake_int_reg;
	logic [5:0]       rst_int_reg;
	logic             cnt_sel_reg;
	logic             therm_en_reg;
	logic             therm_high_reg;
	logic             out_range_reg;
	logic             wake_flag_reg;
	logic             mcu_rst_reg;
	logic [7:0]       rdata_reg;
	logic [1:0]       sync_a_reg;
	logic [1:0]       sync_b_reg;
	logic             in_range_s;
	logic             outside_s;
	logic             sys_rst;
	logic [5:0]       wake_cnt;
	logic [5:0]       rst_cnt;
	logic [5:0]       wake_lim;
	logic             wake_evt;
	logic             rst_evt;
	logic             blocked;
	logic             wake_fire;
	logic             period_rst;
	logic             therm_rst;
	logic             wr_int;
	logic             int_change;
	logic             ack;
	logic [7:0]       rd_mux;
	logic             wr_opt;
	logic             wr_pre;
	logic             wr_rst;
	logic             wr_sts;
	logic             wake_off;
	logic             cnt_restart;
	logic             rst_request;
	logic             en_accept;

	// processor-level reset: our own reset pulse or one from the core
	assign sys_rst = mcu_rst_reg || mcu_reset_req;

	// prescaler and wake counter always restart together
	assign cnt_restart = sys_rst || int_change;

	// temperature detector indications arrive asynchronously;
	// each level has its own pair, they are never used as one word
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync_a_reg <= 2'h0;
		end else begin
			sync_a_reg <= {sync_a_reg[0], temp_pin.in_reset_range};
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync_b_reg <= 2'h0;
		end else begin
			sync_b_reg <= {sync_b_reg[0], temp_pin.outside_rearm};
		end
	end
	// only the second stage of each pair is read
	assign in_range_s = sync_a_reg[1];
	assign outside_s  = sync_b_reg[1];

	// slow oscillator tick; no control reaches this divider
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			osc_cnt_reg <= '0;
		end else if (osc_tick) begin
			osc_cnt_reg <= '0;
		end else begin
			osc_cnt_reg <= osc_cnt_reg + OSC_W'(1);
		end
	end
	// the one rate enable of the block, one clk wide
	assign osc_tick = (osc_cnt_reg == OSC_W'(OSC_CYCLES - 1));

	// prescaler; restarting it with the interval keeps the first timeout full
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pre_cnt_reg <= '0;
		end else if (cnt_restart) begin
			pre_cnt_reg <= '0;
		end else if (osc_tick && wake_clk) begin
			pre_cnt_reg <= '0;
		end else if (osc_tick) begin
			pre_cnt_reg <= pre_cnt_reg + PRE_W'(1);
		end
	end
	assign wake_clk = osc_tick && (pre_cnt_reg >= pre_last(prescale_reg));

	// zero interval keeps the divider at full length but silences the flag
	assign wake_off = (wake_int_reg == 6'h00);
	assign wake_lim = wake_off ? CNT_DISABLED_LIM : wake_int_reg;

	pwt_count6 #(.W(CNT_W)) u_wake_cnt (
		.clk   (clk),
		.reset (reset),
		.clear (cnt_restart),
		.step  (wake_clk),
		.limit (wake_lim),
		.count (wake_cnt),
		.fire  (wake_evt)
	);

	// reset counter runs on wake events even while they are blocked
	pwt_count6 #(.W(CNT_W)) u_rst_cnt (
		.clk   (clk),
		.reset (reset),
		.clear (sys_rst),
		.step  (wake_evt),
		.limit (rst_int_reg),
		.count (rst_cnt),
		.fire  (rst_evt)
	);

	// counters keep running while blocked; only the outputs are gated
	assign blocked    = therm_en_reg && out_range_reg;
	assign period_rst = rst_evt && !blocked;
	assign wake_fire  = wake_evt && !wake_off && !blocked
		&& !rst_evt;
	assign therm_rst  = therm_en_reg && out_range_reg && !outside_s
		&& in_range_s;
	assign rst_request = period_rst || therm_rst;

	// register writes
	assign wr_opt     = bus_req.wr && hit(bus_req.addr, SYS_OPTION_ADDR);
	assign wr_pre     = bus_req.wr && hit(bus_req.addr, WAKE_PRESCALE_ADDR);
	assign wr_int     = bus_req.wr && hit(bus_req.addr, WAKE_INTERVAL_ADDR);
	assign wr_rst     = bus_req.wr && hit(bus_req.addr, RST_INTERVAL_ADDR);
	assign wr_sts     = bus_req.wr && hit(bus_req.addr, WAKE_STATUS_ADDR);
	// same value is no change, so it restarts nothing; its ack bit still clears the flag
	assign int_change = wr_int && (bus_req.wdata[5:0] != wake_int_reg)
		&& !zero_refused(bus_req.wdata[5:0], rst_int_reg);
	assign ack        = wr_int && bus_req.wdata[WAKE_ACK_BIT];
	// enable is only taken while the status shows out of range
	assign en_accept  = wr_opt && bus_req.wdata[THERM_EN_BIT]
		&& out_range_reg;

	// prescale setting survives processor resets, only power-on loads it
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prescale_reg <= PRESCALE_RESET;
		end else if (wr_pre) begin
			prescale_reg <= bus_req.wdata[5:0];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wake_int_reg <= WAKE_INT_RESET;
		end else if (sys_rst) begin
			wake_int_reg <= WAKE_INT_RESET;
		end else if (int_change) begin
			wake_int_reg <= bus_req.wdata[5:0];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rst_int_reg <= RST_INT_RESET;
		end else if (sys_rst) begin
			rst_int_reg <= RST_INT_RESET;
		end else if (wr_rst
			&& !zero_refused(bus_req.wdata[5:0], wake_int_reg)) begin
			rst_int_reg <= bus_req.wdata[5:0];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_sel_reg <= 1'b0;
		end else if (sys_rst) begin
			cnt_sel_reg <= 1'b0;
		end else if (wr_sts) begin
			cnt_sel_reg <= bus_req.wdata[CNT_SEL_BIT];
		end
	end

	// wake flag: a new event in the ack cycle keeps the flag set
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wake_flag_reg <= 1'b0;
		end else if (sys_rst) begin
			wake_flag_reg <= 1'b0;
		end else if (wake_fire) begin
			wake_flag_reg <= 1'b1;
		end else if (ack) begin
			wake_flag_reg <= 1'b0;
		end
	end

	// thermal restart enable: a refused set leaves the old value
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			therm_en_reg <= 1'b0;
		end else if (sys_rst) begin
			therm_en_reg <= 1'b0;
		end else if (en_accept) begin
			therm_en_reg <= 1'b1;
		end else if (wr_opt && !bus_req.wdata[THERM_EN_BIT]) begin
			therm_en_reg <= 1'b0;
		end
	end

	// threshold select lands even when the enable in that write is refused
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			therm_high_reg <= 1'b0;
		end else if (sys_rst) begin
			therm_high_reg <= 1'b0;
		end else if (wr_opt) begin
			therm_high_reg <= bus_req.wdata[THERM_HIGH_BIT];
		end
	end

	// out-of-range status: set by reset, cleared only inside the reset range
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			out_range_reg <= 1'b1;
		end else if (sys_rst || outside_s) begin
			out_range_reg <= 1'b1;
		end else if (in_range_s && !therm_en_reg) begin
			out_range_reg <= 1'b0;
		end
	end

	// processor reset pulse, one cycle; a request during the pulse is
	// dropped, since the core restarts from that pulse anyway
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mcu_rst_reg <= 1'b0;
		end else begin
			mcu_rst_reg <= !mcu_rst_reg && rst_request;
		end
	end

	// readback; the ack bit always reads zero
	always_comb begin
		rd_mux = 8'h00;
		if (hit(bus_req.addr, SYS_OPTION_ADDR)) begin
			rd_mux[THERM_EN_BIT]   = therm_en_reg;
			rd_mux[THERM_HIGH_BIT] = therm_high_reg;
		end else if (hit(bus_req.addr, SYS_TEST_ADDR)) begin
			rd_mux[OUT_RANGE_BIT] = out_range_reg;
		end else if (hit(bus_req.addr, WAKE_PRESCALE_ADDR)) begin
			rd_mux[5:0] = prescale_reg;
		end else if (hit(bus_req.addr, WAKE_INTERVAL_ADDR)) begin
			rd_mux[WAKE_FLAG_BIT] = wake_flag_reg;
			rd_mux[5:0]           = wake_int_reg;
		end else if (hit(bus_req.addr, RST_INTERVAL_ADDR)) begin
			rd_mux[5:0] = rst_int_reg;
		end else if (hit(bus_req.addr, WAKE_STATUS_ADDR)) begin
			rd_mux[CNT_SEL_BIT] = cnt_sel_reg;
			rd_mux[5:0]         = cnt_sel_reg ? rst_cnt : wake_cnt;
		end
	end

	// read data stands one cycle only, zero otherwise
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata_reg <= 8'h00;
		end else if (bus_req.rd) begin
			rdata_reg <= rd_mux;
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	// nothing stands between the flag and the request, so no mask exists
	assign rdata               = rdata_reg;
	assign wake_irq            = wake_flag_reg;
	assign mcu_reset_out       = mcu_rst_reg;
	assign thermal_high_select = therm_high_reg;

endmodule : pwt_wake_timer

// file: pwt_checker.sv
`timescale 1ns/100ps
module pwt_checker
	import pwt_pkg::*;
#(
	parameter int OSC_CYCLES = 4
) (
	input wire logic         clk,
	input wire logic         reset,
	input wire pwt_bus_req_t bus_req,
	input wire logic [7:0]   rdata,
	input wire pwt_temp_t    temp_pin,
	input wire logic         mcu_reset_req,
	input wire logic         wake_irq,
	input wire logic         mcu_reset_out,
	input wire logic         thermal_high_select
);
	logic srst;
	logic ackw;
	logic optw;
	assign srst = mcu_reset_out | mcu_reset_req;
	assign ackw = bus_req.wr && bus_req.addr == WAKE_INTERVAL_ADDR
		&& bus_req.wdata[WAKE_ACK_BIT];
	assign optw = bus_req.wr && bus_req.addr == SYS_OPTION_ADDR;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	rdata_idle_a: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
		else $error("read data outside read slot");
	reset_pulse_a: assert property (mcu_reset_out |=> !mcu_reset_out)
		else $error("reset pulse too long");
	irq_hold_a: assert property (wake_irq && !ackw && !srst |=> wake_irq)
		else $error("wake request dropped");
	irq_clear_a: assert property ($fell(wake_irq) |-> $past(ackw) || $past(srst))
		else $error("wake request cleared without cause");
	reset_clear_a: assert property (srst |=> !wake_irq && !thermal_high_select)
		else $error("processor reset left state set");
	no_coincide_a: assert property (mcu_reset_out |-> !$rose(wake_irq))
		else $error("wake and reset together");
	hisel_write_a: assert property (optw && !srst |=>
		thermal_high_select == $past(bus_req.wdata[THERM_HIGH_BIT]))
		else $error("threshold select not written");
	ack_zero_a: assert property (bus_req.rd && bus_req.addr ==
		WAKE_INTERVAL_ADDR |=> !rdata[WAKE_ACK_BIT])
		else $error("acknowledge bit reads one");
endmodule : pwt_checker

bind pwt_wake_timer pwt_checker #(.OSC_CYCLES(OSC_CYCLES)) u_chk (
	.clk                 (clk),
	.reset               (reset),
	.bus_req             (bus_req),
	.rdata               (rdata),
	.temp_pin            (temp_pin),
	.mcu_reset_req       (mcu_reset_req),
	.wake_irq            (wake_irq),
	.mcu_reset_out       (mcu_reset_out),
	.thermal_high_select (thermal_high_select)
);

// file: pwt_mcu_model.sv
`timescale 1ns/100ps
module pwt_mcu_model (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic wake_irq,
	input  wire logic mcu_reset_out,
	input  wire logic soft_rst_cmd,
	output logic      mcu_reset_req,
	output int        rst_count,
	output int        wake_count
);
	logic irq_d;
	// other core reset sources, one cycle wide
	always_ff @(posedge clk or posedge reset) begin
		if (reset) mcu_reset_req <= 1'b0;
		else mcu_reset_req <= soft_rst_cmd & ~mcu_reset_req;
	end
	// each pulse restarts the core from its reset vector
	always_ff @(posedge clk or posedge reset) begin
		if (reset) rst_count <= 0;
		else if (mcu_reset_out) rst_count <= rst_count + 1;
	end
	// core has no mask on this request, so every rise is taken
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_d      <= 1'b0;
			wake_count <= 0;
		end else begin
			irq_d <= wake_irq;
			if (wake_irq && !irq_d) wake_count <= wake_count + 1;
		end
	end
endmodule : pwt_mcu_model

// file: testbench.sv
`timescale 1ns/100ps
module testbench;
	import pwt_pkg::*;
	localparam int OSC = 4;
	logic         clk = 1'b0;
	logic         reset = 1'b1;
	logic         soft_rst_cmd = 1'b0;
	logic         rd_d = 1'b0;
	pwt_bus_req_t bus_req = '0;
	pwt_temp_t    temp_pin = '0;
	logic [7:0]   rdata;
	logic         mcu_reset_req, wake_irq, mcu_reset_out, thermal_high_select;
	int           rst_count, wake_count, miscompares = 0, check_count = 0;
	logic [16:0]  rnd = 17'h16DA5;
	logic [15:0]  expq[$];
	always #5 clk = ~clk;
	pwt_wake_timer #(.OSC_CYCLES(OSC)) uut (.clk(clk), .reset(reset),
		.bus_req(bus_req), .rdata(rdata), .temp_pin(temp_pin),
		.mcu_reset_req(mcu_reset_req), .wake_irq(wake_irq),
		.mcu_reset_out(mcu_reset_out),
		.thermal_high_select(thermal_high_select));
	pwt_mcu_model mcu (.clk(clk), .reset(reset), .wake_irq(wake_irq),
		.mcu_reset_out(mcu_reset_out), .soft_rst_cmd(soft_rst_cmd),
		.mcu_reset_req(mcu_reset_req), .rst_count(rst_count),
		.wake_count(wake_count));
	function automatic logic [16:0] lfsr(input logic [16:0] v);
		return {v[15:0], v[16] ^ v[13]};
	endfunction : lfsr
	task automatic final_report;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	task automatic chk(input logic ok, input string m);
		check_count++;
		if (!ok) begin
			miscompares++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus_req <= '0;
	endtask : wr
	// expected value travels with its mask: {mask, value}
	task automatic rd(input logic [15:0] a, input logic [7:0] m, e);
		expq.push_back({m, e});
		@(posedge clk);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus_req <= '0;
	endtask : rd
	// sel 0 waits for the wake request, 1 for the reset pulse
	task automatic await(input int sel, lim, output int n);
		n = 0;
		while ((sel ? mcu_reset_out : wake_irq) !== 1'b1 && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= lim) begin
			chk(1'b0, "wait ran out");
			final_report();
		end
	endtask : await
	always @(posedge clk) rd_d <= bus_req.rd;
	always @(negedge clk) if (rd_d === 1'b1) begin : cmp
		logic [15:0] x;
		x = expq.pop_front();
		chk((rdata & x[15:8]) === x[7:0], "read data");
	end
	initial begin
		int n, iv, p, wclk;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		rd(SYS_OPTION_ADDR, 8'h0C, 8'h00);
		rd(SYS_TEST_ADDR, 8'h01, 8'h01);
		rd(WAKE_PRESCALE_ADDR, 8'h3F, 8'h1F);
		rd(WAKE_INTERVAL_ADDR, 8'hFF, 8'h3F);
		rd(16'h1830, 8'hFF, 8'h00);
		$display("test done: reset values");
		temp_pin <= '{1'b1, 1'b0};
		repeat (6) @(posedge clk);
		rd(SYS_TEST_ADDR, 8'h01, 8'h00);
		wr(SYS_OPTION_ADDR, 8'h0C);
		rd(SYS_OPTION_ADDR, 8'h0C, 8'h04);
		chk(thermal_high_select === 1'b1, "select pin");
		temp_pin <= '{1'b0, 1'b1};
		repeat (6) @(posedge clk);
		rnd = lfsr(rnd);
		p = rnd % 4;
		wclk = (PRESCALE_BASE + PRESCALE_STEP * p) * OSC;
		wr(WAKE_PRESCALE_ADDR, p[7:0]);
		wr(WAKE_INTERVAL_ADDR, 8'h01);
		wr(SYS_OPTION_ADDR, 8'h08);
		rd(SYS_OPTION_ADDR, 8'h0C, 8'h08);
		repeat (2 * wclk) @(posedge clk);
		chk(wake_count == 0 && rst_count == 0, "not blocked");
		temp_pin <= '{1'b1, 1'b0};
		await(1, 20, n);
		rd(SYS_OPTION_ADDR, 8'h0C, 8'h00);
		rd(WAKE_PRESCALE_ADDR, 8'h3F, p[7:0]);
		$display("test done: thermal restart");
		wr(RST_INTERVAL_ADDR, 8'h02);
		wr(WAKE_INTERVAL_ADDR, 8'h01);
		await(0, wclk + 20, n);
		chk(n > wclk - 20, "first wake");
		wr(WAKE_INTERVAL_ADDR, 8'h41);
		await(1, wclk + 20, n);
		chk(n > wclk - 40, "periodic reset");
		rd(WAKE_INTERVAL_ADDR, 8'hFF, 8'h3F);
		chk(wake_count == 1 && rst_count == 2, "reset beats wake");
		$display("test done: periodic reset");
		rnd = lfsr(rnd);
		iv = rnd % 3 + 1;
		wr(WAKE_INTERVAL_ADDR, iv[7:0]);
		await(0, iv * wclk + 20, n);
		chk(n > iv * wclk - 20, "wake interval");
		rd(WAKE_STATUS_ADDR, 8'hBF, 8'h00);
		rd(WAKE_INTERVAL_ADDR, 8'hFF, {2'b10, iv[5:0]});
		wr(WAKE_INTERVAL_ADDR, {2'b01, iv[5:0]});
		rd(WAKE_INTERVAL_ADDR, 8'hC0, 8'h00);
		wr(WAKE_STATUS_ADDR, 8'h80);
		rd(WAKE_STATUS_ADDR, 8'hBF, 8'h81);
		$display("test done: wake interval");
		wr(WAKE_INTERVAL_ADDR, 8'h00);
		rd(WAKE_INTERVAL_ADDR, 8'h3F, iv[7:0]);
		wr(RST_INTERVAL_ADDR, 8'h05);
		wr(WAKE_INTERVAL_ADDR, 8'h00);
		rd(WAKE_INTERVAL_ADDR, 8'h3F, 8'h00);
		wr(RST_INTERVAL_ADDR, 8'h00);
		rd(RST_INTERVAL_ADDR, 8'h3F, 8'h05);
		$display("test done: disable limits");
		wr(SYS_OPTION_ADDR, 8'h04);
		soft_rst_cmd <= 1'b1;
		@(posedge clk);
		soft_rst_cmd <= 1'b0;
		rd(SYS_OPTION_ADDR, 8'h0C, 8'h00);
		rd(WAKE_INTERVAL_ADDR, 8'h3F, 8'h3F);
		rd(RST_INTERVAL_ADDR, 8'h3F, 8'h00);
		$display("test done: core reset");
		repeat (3) @(posedge clk);
		final_report();
	end
endmodule : testbench
